// [core/rie_core.sv]
/*
 * single-cycle execute core for jumps, calls, stack, moves, shifts,
 * complements and increments, with an avalon-mm control slave.
 * assumes combinational-read program and data memories on sys_clk_in.
 */
// Behaviour
// - jump always loads pc from target or index; conditional jumps only if condition true; no flags
// - call shifts stack down, saves next pc on top, jumps
// - short call saves next pc in index register; short return jumps there
// - return pops top into pc; interrupt return also sets global enable
// - push advances pc, shifts stack down, stores index register on top
// - pop advances pc, loads index register from top, shifts stack up
// - register moves write accumulator and destination, zero only; memory moves no flags
// - move-if-carry-clear always writes accumulator, destination only when carry is 0
// - move-if-carry-set always writes accumulator, destination only when carry is 1
// - shift left inserts 0, old bit 7 into carry; updates carry, overflow, zero
// - shift left through carry inserts old carry, old bit 7 into carry
// - shift right clears bit 7, old bit 0 into carry
// - shift right through carry inserts old carry at bit 7, bit 0 to carry
// - arithmetic shift right keeps bit 7, old bit 0 into carry
// - ones complement inverts operand, updates zero only
// - twos complement negates; carry set exactly when result is zero
// - twos complement with carry adds carry; carry set if zero and carry was 1
// - increment adds one; carry set when result wraps to zero
// - increment with carry adds carry; carry set if zero and carry was 1
// - every instruction completes in one clock cycle
// - zero flag equals accumulator being zero after flag-updating instructions
// - sixteen 8-bit internal registers selected by register operands
module rie_core import rie_pkg::*; #(
	parameter int STACK_DEPTH = 8
) (
	// clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// program memory
	output logic [15:0] pmem_addr_out,
	input wire logic [21:0] instr_in,
	// data memory
	output logic [15:0] dmem_raddr_out,
	input wire logic [7:0] dmem_rdata_in,
	output logic dmem_we_out,
	output logic [15:0] dmem_waddr_out,
	output logic [7:0] dmem_wdata_out,
	// avalon-mm slave
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out
);

	typedef struct packed {
		logic [15:0] pc;
		logic [15:0][7:0] rf;
		logic [STACK_DEPTH-1:0][15:0] stk;
		logic c;
		logic v;
		logic z;
		logic run;
		logic dm_we;
		logic [15:0] dm_wa;
		logic [7:0] dm_wd;
		logic bus_wait;
		logic [31:0] bus_rd;
	} rie_state_t;

	rie_state_t st_q;
	rie_state_t st_d;

	// ****************************************
	// address generation unit
	// ****************************************
	// index pair plus short offset; swap this function for the full mode set
	function automatic logic [15:0] rie_agu(input logic [15:0][7:0] rf, input logic [7:0] ea);
		logic [3:0] hi;
		hi = RI_I0H + {1'b0, ea[EA_SEL_HI:EA_SEL_LO], 1'b0};
		return {rf[hi], rf[hi + 4'h1]} + {10'h000, ea[EA_OFS_HI:0]};
	endfunction

	// ****************************************
	// instruction decode
	// ****************************************
	rie_op_t op;
	logic mode;
	logic [3:0] r1;
	logic [3:0] r2;
	logic [7:0] imm;
	logic [15:0] ip;
	logic [15:0] ea;
	logic [15:0] pc_inc;
	logic [15:0] tgt;
	logic [7:0] dm_rd;
	logic [7:0] src;
	logic ex;

	assign op = rie_op_t'(instr_in[OP_HI:OP_LO]);
	assign mode = instr_in[MODE_BIT];
	assign r1 = instr_in[R1_HI:R1_LO];
	assign r2 = instr_in[R2_HI:R2_LO];
	assign imm = instr_in[IMM_HI:IMM_LO];
	assign ip = {st_q.rf[RI_IPH], st_q.rf[RI_IPL]};
	assign ea = rie_agu(st_q.rf, imm);
	assign pc_inc = st_q.pc + PC_STEP;
	assign tgt = mode ? ip : instr_in[R1_HI:IMM_LO];
	assign ex = ce_in && st_q.run;
	// read port is combinational so one instruction fits one cycle
	assign dmem_raddr_out = ea;
	// forward the posted write so a read right after it sees fresh data
	assign dm_rd = (st_q.dm_we && st_q.dm_wa == ea) ? st_q.dm_wd : dmem_rdata_in;
	assign src = mode ? dm_rd : st_q.rf[r2];

	// ****************************************
	// return stack shifters
	// ****************************************
	logic [STACK_DEPTH-1:0][15:0] stk_dn;
	logic [STACK_DEPTH-1:0][15:0] stk_up;

	genvar g;
	generate
		for (g = 0; g < STACK_DEPTH; g++) begin : g_stk
			if (g == 0) begin : g_top
				assign stk_dn[g] = 16'h0000;
			end else begin : g_mid
				assign stk_dn[g] = st_q.stk[g-1];
			end
			if (g == STACK_DEPTH - 1) begin : g_bot
				assign stk_up[g] = 16'h0000; // bottom empties to zero
			end else begin : g_low
				assign stk_up[g] = st_q.stk[g+1];
			end
		end
	endgenerate

	// ****************************************
	// next state
	// ****************************************
	logic [7:0] res;
	logic wr_a;
	logic wr_r1;
	logic upd_z;
	logic cnd;

	always_comb begin
		st_d = st_q;
		res = 8'h00;
		wr_a = 1'b0;
		wr_r1 = 1'b0;
		upd_z = 1'b0;
		cnd = 1'b0;
		st_d.dm_we = 1'b0;
		// bus: one wait cycle, then answer for exactly one edge
		st_d.bus_wait = 1'b1;
		if ((avs_read_in || avs_write_in) && st_q.bus_wait) begin
			st_d.bus_wait = 1'b0;
			if (avs_address_in == REG_CTRL) begin
				st_d.bus_rd = {31'h00000000, st_q.run};
			end else if (avs_address_in == REG_FLAGS) begin
				st_d.bus_rd = {29'h00000000, st_q.z, st_q.v, st_q.c};
			end else if (avs_address_in == REG_PC) begin
				st_d.bus_rd = {16'h0000, st_q.pc};
			end else if (avs_address_in == REG_ACC) begin
				st_d.bus_rd = {24'h000000, st_q.rf[RI_ACC]};
			end else begin
				st_d.bus_rd = 32'h00000000;
			end
		end
		if (avs_write_in && !st_q.bus_wait && avs_address_in == REG_CTRL) begin
			st_d.run = avs_writedata_in[CTRL_RUN_BIT];
		end
		// execute: every opcode retires in this one cycle
		if (st_q.run) begin
			st_d.pc = pc_inc;
			case (op)
				OP_JUMP: st_d.pc = tgt;
				OP_JC, OP_JNC, OP_JZ, OP_JNZ: begin
					case (op)
						OP_JC: cnd = st_q.c;
						OP_JNC: cnd = !st_q.c;
						OP_JZ: cnd = st_q.z;
						default: cnd = !st_q.z;
					endcase
					if (cnd) begin
						st_d.pc = tgt;
					end
				end
				OP_CALL: begin
					st_d.stk = stk_dn;
					st_d.stk[0] = pc_inc;
					st_d.pc = tgt;
				end
				OP_CALLS: begin
					{st_d.rf[RI_IPH], st_d.rf[RI_IPL]} = pc_inc;
					st_d.pc = tgt;
				end
				OP_RET, OP_RETI: begin
					st_d.pc = st_q.stk[0];
					st_d.stk = stk_up;
					if (op == OP_RETI) begin
						st_d.rf[RI_STAT][STAT_GIE_BIT] = 1'b1;
					end
				end
				OP_RETS: st_d.pc = ip;
				OP_PUSH: begin
					st_d.stk = stk_dn;
					st_d.stk[0] = ip;
				end
				OP_POP: begin
					{st_d.rf[RI_IPH], st_d.rf[RI_IPL]} = st_q.stk[0];
					st_d.stk = stk_up;
				end
				OP_MOVI, OP_MOVR: begin
					res = (op == OP_MOVI) ? imm : src;
					wr_a = 1'b1;
					wr_r1 = 1'b1;
					upd_z = 1'b1;
				end
				OP_MOVRD: begin
					st_d.dm_we = 1'b1;
					st_d.dm_wa = ea;
					st_d.dm_wd = st_q.rf[r1];
				end
				OP_MOVAI: begin
					st_d.dm_we = 1'b1;
					st_d.dm_wa = {8'h00, instr_in[R1_HI:R2_LO]};
					st_d.dm_wd = imm;
				end
				OP_CMVD, OP_CMVS: begin
					res = src;
					wr_a = 1'b1;
					upd_z = 1'b1;
					wr_r1 = (op == OP_CMVD) ? !st_q.c : st_q.c;
				end
				OP_SHL, OP_SHIFT_LEFT_THRU_CARRY: begin
					res = {src[6:0], (op == OP_SHIFT_LEFT_THRU_CARRY) && st_q.c};
					st_d.c = src[7];
					st_d.v = src[7] ^ src[6];
					wr_a = 1'b1;
					wr_r1 = 1'b1;
					upd_z = 1'b1;
				end
				OP_SHR, OP_SHRC, OP_SHRA: begin
					if (op == OP_SHR) begin
						res = {1'b0, src[7:1]};
					end else if (op == OP_SHRC) begin
						res = {st_q.c, src[7:1]};
					end else begin
						res = {src[7], src[7:1]};
					end
					st_d.c = src[0];
					st_d.v = 1'b0; // right shifts cannot overflow
					wr_a = 1'b1;
					wr_r1 = 1'b1;
					upd_z = 1'b1;
				end
				OP_ONES_COMPLEMENT: begin
					res = ~src;
					wr_a = 1'b1;
					wr_r1 = 1'b1;
					upd_z = 1'b1;
				end
				OP_TWOS_COMPLEMENT, OP_TWOS_COMPLEMENT_CARRY, OP_INC, OP_INCC: begin
					if (op == OP_TWOS_COMPLEMENT) begin
						res = ~src + ONE8;
					end else if (op == OP_TWOS_COMPLEMENT_CARRY) begin
						res = ~src + {7'h00, st_q.c};
					end else if (op == OP_INC) begin
						res = src + ONE8;
					end else begin
						res = src + {7'h00, st_q.c};
					end
					if (op == OP_TWOS_COMPLEMENT || op == OP_INC) begin
						st_d.c = (res == 8'h00);
					end else begin
						st_d.c = (res == 8'h00) && st_q.c;
					end
					if (op == OP_TWOS_COMPLEMENT || op == OP_TWOS_COMPLEMENT_CARRY) begin
						st_d.v = (src == MIN_NEG8);
					end else begin
						st_d.v = !src[7] && res[7];
					end
					wr_a = 1'b1;
					wr_r1 = 1'b1;
					upd_z = 1'b1;
				end
				default: ;
			endcase
			if (wr_r1) begin
				st_d.rf[r1] = res;
			end
			if (wr_a) begin
				st_d.rf[RI_ACC] = res;
			end
			if (upd_z) begin
				st_d.z = (res == 8'h00);
			end
		end
	end

	// state register; enable low freezes core and bus alike
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			st_q <= '0;
			st_q.pc <= PC_RST;
			st_q.run <= CTRL_RUN_RST;
			st_q.bus_wait <= 1'b1;
		end else if (ce_in) begin
			st_q <= st_d;
		end
	end

	assign pmem_addr_out = st_q.pc;
	assign dmem_we_out = st_q.dm_we;
	assign dmem_waddr_out = st_q.dm_wa;
	assign dmem_wdata_out = st_q.dm_wd;
	assign avs_readdata_out = st_q.bus_rd;
	assign avs_waitrequest_out = st_q.bus_wait;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);

	sequence s_call;
		ex && op == OP_CALL;
	endsequence
	sequence s_ret;
		ex && op == OP_RET;
	endsequence

	a_jump_taken: assert property (ex && op == OP_JUMP && !mode |=>
		st_q.pc == $past(instr_in[15:0])) else $error("jump target not loaded");
	a_jcc_not_taken: assert property (ex && op == OP_JC && !st_q.c |=>
		st_q.pc == $past(st_q.pc) + PC_STEP && st_q.c == $past(st_q.c))
		else $error("false condition jumped");
	a_call_push: assert property (s_call |=> st_q.stk[0] == $past(pc_inc) &&
		st_q.stk[1] == $past(st_q.stk[0])) else $error("call did not push");
	a_call_ret_pair: assert property (s_call ##1 s_ret |=>
		st_q.pc == $past(st_q.pc, 2) + PC_STEP) else $error("return address lost");
	a_short_call: assert property (ex && op == OP_CALLS |=>
		{st_q.rf[RI_IPH], st_q.rf[RI_IPL]} == $past(pc_inc)) else $error("short call");
	a_reti_gie: assert property (ex && op == OP_RETI |=>
		st_q.rf[RI_STAT][STAT_GIE_BIT]) else $error("global enable not set");
	a_push_pop: assert property (ex && op == OP_PUSH ##1 ex && op == OP_POP |=>
		{st_q.rf[RI_IPH], st_q.rf[RI_IPL]} == $past(ip, 2)) else $error("push pop lost");
	a_cmvd_keep: assert property (ex && op == OP_CMVD && st_q.c && r1 != RI_ACC |=>
		st_q.rf[$past(r1)] == $past(st_q.rf[r1])) else $error("conditional move wrote");
	a_shl_carry: assert property (ex && op == OP_SHL && !mode |=>
		st_q.c == $past(st_q.rf[r2][7]) && !st_q.rf[RI_ACC][0]) else $error("shift carry");
	a_inc_wrap: assert property (ex && op == OP_INC && !mode && st_q.rf[r2] == 8'hFF |=>
		st_q.c && st_q.z && st_q.rf[RI_ACC] == 8'h00) else $error("increment wrap");
	a_twos_complement_carry: assert property (ex && op == OP_TWOS_COMPLEMENT && !mode |=>
		st_q.c == (st_q.rf[RI_ACC] == 8'h00)) else $error("negate carry");
	a_zero_flag: assert property (ex && op == OP_ONES_COMPLEMENT |=>
		st_q.z == (st_q.rf[RI_ACC] == 8'h00)) else $error("zero flag mismatch");

endmodule

// [pkg/rie_pkg.sv]
/*
 * shared constants for the instruction execute core: instruction fields,
 * opcodes, register-file indices and the register map of the bus slave.
 * assumes a 22-bit instruction word presented by program memory.
 */
package rie_pkg;

	// ****************************************
	// instruction fields
	// ****************************************
	localparam int OP_HI = 21;
	localparam int OP_LO = 17;
	localparam int MODE_BIT = 16;
	localparam int R1_HI = 15;
	localparam int R1_LO = 12;
	localparam int R2_HI = 11;
	localparam int R2_LO = 8;
	localparam int IMM_HI = 7;
	localparam int IMM_LO = 0;
	localparam int EA_SEL_HI = 7;
	localparam int EA_SEL_LO = 6;
	localparam int EA_OFS_HI = 5;

	typedef enum logic [4:0] {
		OP_NOP = 5'h00, OP_JUMP = 5'h01, OP_JC = 5'h02, OP_JNC = 5'h03,
		OP_JZ = 5'h04, OP_JNZ = 5'h05, OP_CALL = 5'h06, OP_CALLS = 5'h07,
		OP_RET = 5'h08, OP_RETS = 5'h09, OP_RETI = 5'h0A, OP_PUSH = 5'h0B,
		OP_POP = 5'h0C, OP_MOVI = 5'h0D, OP_MOVR = 5'h0E, OP_MOVRD = 5'h0F,
		OP_MOVAI = 5'h10, OP_CMVD = 5'h11, OP_CMVS = 5'h12, OP_SHL = 5'h13,
		OP_SHIFT_LEFT_THRU_CARRY = 5'h14, OP_SHR = 5'h15, OP_SHRC = 5'h16, OP_SHRA = 5'h17,
		OP_ONES_COMPLEMENT = 5'h18, OP_TWOS_COMPLEMENT = 5'h19, OP_TWOS_COMPLEMENT_CARRY = 5'h1A, OP_INC = 5'h1B,
		OP_INCC = 5'h1C
	} rie_op_t;

	// ****************************************
	// register file indices
	// ****************************************
	localparam logic [3:0] RI_I0H = 4'h4;
	localparam logic [3:0] RI_IPH = 4'hC;
	localparam logic [3:0] RI_IPL = 4'hD;
	localparam logic [3:0] RI_STAT = 4'hE;
	localparam logic [3:0] RI_ACC = 4'hF;
	localparam int STAT_GIE_BIT = 5;

	// ****************************************
	// bus register map
	// ****************************************
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_FLAGS = 4'h4;
	localparam logic [3:0] REG_PC = 4'h8;
	localparam logic [3:0] REG_ACC = 4'hC;
	localparam int CTRL_RUN_BIT = 0;
	localparam logic CTRL_RUN_RST = 1'b1;
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [15:0] PC_STEP = 16'h0001;
	localparam logic [7:0] ONE8 = 8'h01;
	localparam logic [7:0] MIN_NEG8 = 8'h80;

endpackage

// [dv/rie_mem_model.sv]
/*
 * program and data memory model standing beside the execute core.
 * assumes the bench fills prog before the core starts fetching.
 */
module rie_mem_model (
	// clock
	input wire logic sys_clk_in,
	// program memory
	input wire logic [15:0] pmem_addr_in,
	output logic [21:0] instr_out,
	// data memory
	input wire logic [15:0] dmem_raddr_in,
	output logic [7:0] dmem_rdata_out,
	input wire logic dmem_we_in,
	input wire logic [15:0] dmem_waddr_in,
	input wire logic [7:0] dmem_wdata_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [21:0] prog [256];
	logic [7:0] dm [65536];
	// code aliases on the low byte so every jump target holds a word
	assign instr_out = prog[pmem_addr_in[7:0]];
	assign dmem_rdata_out = dm[dmem_raddr_in];
	// seeded cells, so a stale read differs from a fresh one
	initial for (int i = 0; i < 65536; i++) dm[i] = 8'(i * 37 + 5);
	// posted write lands at the edge that sees the strobe
	always @(posedge sys_clk_in) if (dmem_we_in) dm[dmem_waddr_in] <= dmem_wdata_in;
endmodule

// [dv/tb_top.sv]
/*
 * self-checking bench: random programs run in lock-step with a model;
 * state is read back over the control bus while the core is halted.
 * assumes rie_core, rie_mem_model and one 25 MHz clock.
 */
module tb_top import rie_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// signals
	// ****************
	localparam int DEPTH = 4;
	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic ce_in = 1'b1;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [3:0] avs_address_in = 4'h0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [31:0] avs_readdata_out, rdv;
	logic avs_waitrequest_out, dmem_we_out;
	logic [21:0] instr_in;
	logic [7:0] dmem_rdata_in, dmem_wdata_out;
	logic [15:0] pmem_addr_out, dmem_raddr_out, dmem_waddr_out;
	int n_mismatch = 0;
	int total_checks = 0;
	// model state; a short stack makes overflow common
	logic [15:0] m_pc, m_wa;
	logic [15:0] m_st [DEPTH];
	logic [7:0] m_rf [16];
	logic [7:0] m_dm [65536];
	logic [7:0] m_wd;
	logic m_c, m_z, m_run, m_we, m_chk, m_v;
	// 25 MHz clock
	initial forever #20 sys_clk_in = ~sys_clk_in;
	rie_core #(.STACK_DEPTH(DEPTH)) rie_core_i (.sys_clk_in, .rst_in, .ce_in, .pmem_addr_out,
		.instr_in, .dmem_raddr_out, .dmem_rdata_in, .dmem_we_out, .dmem_waddr_out,
		.dmem_wdata_out, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
		.avs_readdata_out, .avs_waitrequest_out);
	rie_mem_model rie_mem_model_i (.sys_clk_in, .pmem_addr_in(pmem_addr_out),
		.instr_out(instr_in), .dmem_raddr_in(dmem_raddr_out), .dmem_rdata_out(dmem_rdata_in),
		.dmem_we_in(dmem_we_out), .dmem_waddr_in(dmem_waddr_out), .dmem_wdata_in(dmem_wdata_out));
	// ****************
	// tasks
	// ****************
	// one comparison
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one executed word; stack shifts by loop so any depth works
	task automatic step(logic [21:0] w);
		logic [4:0] op;
		logic [3:0] r1;
		logic [7:0] s, a;
		logic [15:0] ip, ea, nx, tg, v;
		logic wa, wr;
		int p;
		op = w[OP_HI:OP_LO];
		r1 = w[R1_HI:R1_LO];
		p = RI_I0H + 2 * w[EA_SEL_HI:EA_SEL_LO];
		ip = {m_rf[RI_IPH], m_rf[RI_IPL]};
		ea = {m_rf[p], m_rf[p + 1]} + 16'(w[EA_OFS_HI:0]);
		s = w[MODE_BIT] ? m_dm[ea] : m_rf[w[R2_HI:R2_LO]];
		tg = w[MODE_BIT] ? ip : w[15:0];
		nx = m_pc + PC_STEP;
		v = m_st[0];
		a = s;
		wa = op inside {OP_MOVI, OP_MOVR, [OP_CMVD:OP_INCC]};
		wr = wa;
		if (op inside {OP_CALL, OP_PUSH}) begin
			for (int i = DEPTH - 1; i > 0; i--) m_st[i] = m_st[i - 1];
			m_st[0] = op == OP_CALL ? nx : ip;
		end
		if (op inside {OP_RET, OP_RETI, OP_POP}) begin
			for (int i = 0; i < DEPTH - 1; i++) m_st[i] = m_st[i + 1];
			m_st[DEPTH - 1] = 16'h0000;
		end
		case (op)
			OP_JUMP, OP_CALL: nx = tg;
			OP_JC: nx = m_c ? tg : nx;
			OP_JNC: nx = m_c ? nx : tg;
			OP_JZ: nx = m_z ? tg : nx;
			OP_JNZ: nx = m_z ? nx : tg;
			OP_CALLS: {m_rf[RI_IPH], m_rf[RI_IPL], nx} = {nx, tg};
			OP_RET: nx = v;
			OP_RETI: {m_rf[RI_STAT][STAT_GIE_BIT], nx} = {1'b1, v};
			OP_RETS: nx = ip;
			OP_POP: {m_rf[RI_IPH], m_rf[RI_IPL]} = v;
			OP_MOVI: a = w[IMM_HI:IMM_LO];
			OP_MOVRD, OP_MOVAI: begin
				m_we = 1'b1;
				m_wa = op == OP_MOVRD ? ea : {8'h00, w[15:8]};
				m_wd = op == OP_MOVRD ? m_rf[r1] : w[7:0];
				m_dm[m_wa] = m_wd;
			end
			OP_CMVD: wr = !m_c;
			OP_CMVS: wr = m_c;
			OP_SHL, OP_SHIFT_LEFT_THRU_CARRY: {m_c, a} = {s, op == OP_SHIFT_LEFT_THRU_CARRY && m_c};
			OP_SHR, OP_SHRC, OP_SHRA: {a, m_c} = {op == OP_SHRC ? m_c : op == OP_SHRA && s[7], s};
			OP_ONES_COMPLEMENT: a = ~s;
			OP_TWOS_COMPLEMENT, OP_TWOS_COMPLEMENT_CARRY: begin
				a = ~s + (op == OP_TWOS_COMPLEMENT ? ONE8 : {7'h00, m_c});
				m_c = a == 8'h00 && (op == OP_TWOS_COMPLEMENT || m_c);
			end
			OP_INC, OP_INCC: begin
				a = s + (op == OP_INC ? ONE8 : {7'h00, m_c});
				m_c = a == 8'h00 && (op == OP_INC || m_c);
			end
			default: ;
		endcase
		// overflow follows the chosen per-group definitions
		if (op inside {OP_SHL, OP_SHIFT_LEFT_THRU_CARRY}) m_v = s[7] ^ s[6];
		if (op inside {OP_SHR, OP_SHRC, OP_SHRA}) m_v = 1'b0;
		if (op inside {OP_TWOS_COMPLEMENT, OP_TWOS_COMPLEMENT_CARRY}) m_v = s == MIN_NEG8;
		if (op inside {OP_INC, OP_INCC}) m_v = !s[7] && a[7];
		if (wr) m_rf[r1] = a;
		if (wa) {m_rf[RI_ACC], m_z} = {a, a == 8'h00};
		m_pc = nx;
	endtask
	// one avalon access, held until waitrequest is seen low
	task automatic bus(logic wr, logic [3:0] ad, logic [31:0] wd);
		@(posedge sys_clk_in);
		avs_address_in <= ad;
		avs_writedata_in <= wd;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
		rdv = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
	endtask
	// random program; round 1 leans on the stack, round 3 on carry corners
	task automatic load(int r);
		logic [21:0] w;
		rie_op_t op;
		for (int i = 0; i < 256; i++) begin
			w = 22'($urandom());
			op = rie_op_t'(r == 3 ? $urandom_range(28, 2) : $urandom_range(28));
			if (r == 1) op = rie_op_t'($urandom_range(12, 6));
			if (r == 3) w[7:0] = {8{w[0]}} ^ {w[1], 7'h00};
			w[MODE_BIT] = op == OP_MOVRD || (w[MODE_BIT] && !(op inside {[OP_RET:OP_MOVI],
				OP_MOVAI, OP_NOP}));
			w[OP_HI:OP_LO] = op;
			rie_mem_model_i.prog[i] = w;
		end
	endtask
	// expected bus read while halted
	function automatic logic [31:0] exp_reg(logic [3:0] k);
		case (k)
			REG_PC: return 32'(m_pc);
			REG_ACC: return 32'(m_rf[RI_ACC]);
			REG_FLAGS: return {29'h0, m_z, m_v, m_c};
			default: return 32'h0;
		endcase
	endfunction
	// verdict
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ****************
	// processes
	// ****************
	// model steps on the core's edges; a run write lands after that edge's step
	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			{m_pc, m_run, m_c, m_z, m_we, m_v} = {PC_RST, CTRL_RUN_RST, 4'h0};
			foreach (m_rf[i]) m_rf[i] = 8'h00;
			foreach (m_st[i]) m_st[i] = 16'h0000;
		end else if (ce_in) begin
			m_we = 1'b0;
			if (m_run) step(rie_mem_model_i.prog[m_pc[7:0]]);
			if (avs_write_in && !avs_waitrequest_out && avs_address_in == REG_CTRL)
				m_run = avs_writedata_in[CTRL_RUN_BIT];
		end
		m_chk = ce_in || rst_in;
	end
	// outputs have settled by the falling edge; strobe skipped after a frozen edge
	always @(negedge sys_clk_in) begin
		if (!rst_in) begin
			chk("pc", 32'(m_pc), 32'(pmem_addr_out));
			if (m_chk) begin
				chk("write strobe", 32'(m_we), 32'(dmem_we_out));
				if (m_we) chk("write word", 32'({m_wa, m_wd}), 32'({dmem_waddr_out, dmem_wdata_out}));
			end
		end
	end
	// rounds: run, halt, write every address, read every address back
	initial begin
		void'($urandom(20263));
		for (int i = 0; i < 65536; i++) m_dm[i] = 8'(i * 37 + 5);
		load(0);
		repeat (10) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		for (int r = 0; r < 4; r++) begin
			if (r == 2) begin
				rst_in <= 1'b1;
				@(posedge sys_clk_in);
				rst_in <= 1'b0;
			end else if (r > 0) begin
				bus(1'b1, REG_CTRL, 32'h1);
			end
			repeat (1500) begin
				@(posedge sys_clk_in);
				ce_in <= $urandom_range(7) != 0;
			end
			@(posedge sys_clk_in);
			ce_in <= 1'b1;
			for (int k = 0; k < 16; k++) bus(1'b1, 4'(k), $urandom() & 32'hFFFFFFFE);
			for (int k = 0; k < 16; k++) begin
				bus(1'b0, 4'(k), 32'h0);
				chk("bus read", exp_reg(4'(k)), rdv);
			end
			$display("round %0d done", r);
			if (r < 3) load(r + 1);
		end
		complete_run();
	end
	// hang guard: the rounds need about 6400 cycles
	initial begin
		#(40 * 20000);
		n_mismatch++;
		$display("Error watchdog expected finish seen hang");
		complete_run();
	end
endmodule
